// [tpd_regs.vh]
/*
 * Constants for the calibration and debug test-point port: register
 * offsets, field positions, reset values and output clock timing.
 * Assumes the includer works on a 50 MHz system clock.
 */
`ifndef TPD_REGS_VH
`define TPD_REGS_VH

// ----------------------------------------------------------------------
// register word indices, decoded from wishbone address bits three to two
// ----------------------------------------------------------------------
`define TPD_OFF_CTRL        2'h0
`define TPD_OFF_DIV         2'h1
`define TPD_OFF_STATUS      2'h2

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define TPD_CTRL_SCEN_LSB   0
`define TPD_CTRL_SCEN_MSB   2
`define TPD_CTRL_MODE_LSB   3
`define TPD_CTRL_MODE_MSB   6
`define TPD_STAT_STRAP_LSB  0
`define TPD_STAT_STRAP_MSB  7
`define TPD_STAT_RUN_BIT    8
`define TPD_STAT_PINS_LSB   16
`define TPD_STAT_PINS_MSB   23

// ----------------------------------------------------------------------
// reset values and scenario codes
// ----------------------------------------------------------------------
`define TPD_SCEN_QUIET      3'h0
`define TPD_SCEN_CLKDBG     3'h2
`define TPD_CTRL_RST        7'h00
`define TPD_PULL_ALL        8'hff
`define TPD_CLKDBG_OE       8'hff
`define TPD_CLKDBG_LEVELS   4'hd

// ----------------------------------------------------------------------
// timing: frequencies in kHz, half-period counts in clk_i cycles
// ----------------------------------------------------------------------
`define TPD_CLK_KHZ         50000
`define TPD_TP0_KHZ         60000
`define TPD_TP1_KHZ         30000
`define TPD_TP7_KHZ         7500
`define TPD_TP2_MIN_KHZ     700
`define TPD_TP2_MAX_KHZ     22500
`define TPD_HALF(f)         (((`TPD_CLK_KHZ / (2 * (f))) < 1) ? 1 : (`TPD_CLK_KHZ / (2 * (f))))
`define TPD_HALF_TP0        `TPD_HALF(`TPD_TP0_KHZ)
`define TPD_HALF_TP1        `TPD_HALF(`TPD_TP1_KHZ)
`define TPD_HALF_TP7        `TPD_HALF(`TPD_TP7_KHZ)
`define TPD_HALF_TP2_SLOW   `TPD_HALF(`TPD_TP2_MIN_KHZ)
`define TPD_HALF_TP2_FAST   `TPD_HALF(`TPD_TP2_MAX_KHZ)

`endif

// [tpd_clk_div.v]
/*
 * Square-wave divider: toggles its output every half_i cycles of clk_i.
 * Assumes half_i is at least one and stays stable while run_i is high.
 */
`timescale 1ns/1ps
module tpd_clk_div #(
	parameter W = 8
) (
	// clock and reset
	input  wire         clk_i,
	input  wire         rst_i,
	// control
	input  wire         run_i,
	input  wire [W-1:0] half_i,
	// divided clock
	output wire         clk_o
);

	reg [W-1:0] cnt_q;
	reg         tog_q;

	assign clk_o = tog_q;

	// ------------------------------------------------------------------
	// half-period counter
	// ------------------------------------------------------------------
	always @(posedge clk_i) begin
		if (rst_i || !run_i) begin
			cnt_q <= {W{1'b0}};
			tog_q <= 1'b0;
		end else if (cnt_q == {W{1'b0}}) begin
			cnt_q <= half_i - {{(W-1){1'b0}}, 1'b1};
			tog_q <= ~tog_q;
		end else begin
			cnt_q <= cnt_q - {{(W-1){1'b0}}, 1'b1};
		end
	end

endmodule

// [tpd_test_port.v]
/*
 * Calibration and debug test-point port with strap capture and a
 * classic Wishbone register slave.
 * Assumes the pins, their strap pullups and the active-low system reset pin
 * come from the board, asynchronous to clk_i; rst_i is this block's own
 * synchronous reset.
 * The board must hold the strap levels steady for a few cycles around
 * the release of the reset pin; a level still moving then is read as
 * its last settled value.
 * A new settable-clock half period takes hold at the next toggle.
 */
// What this block does
// - while the system reset pin is low all test points are inputs, after release they are outputs in the clock-debug scenario only.
// - the pin levels are latched at reset release and set the test configuration until next reset or a write to the control register.
// - straps are sampled only on a low-to-high change of the reset pin, later changes do nothing.
// - every test point has a weak internal pulldown so an unstrapped pin captures as zero.
// - with the all-zero scenario captured, all eight test points stay high impedance.
// - strap bits six to three select an operating mode apart from the scenario in bits two to zero.
// - in the clock-debug scenario points zero and one both carry the same fast clock.
// - in the clock-debug scenario point two carries a settable clock and point seven the slow clock.
// - software may overwrite the strap-derived output selection at any time after reset.
`timescale 1ns/1ps
`include "tpd_regs.vh"
module tpd_test_port #(
	parameter DIV_W = 8
) (
	// clock and block reset
	input  wire        clk_i,
	input  wire        rst_i,
	// wishbone slave
	input  wire        wb_cyc_i,
	input  wire        wb_stb_i,
	input  wire        wb_we_i,
	input  wire [3:0]  wb_adr_i,
	input  wire [3:0]  wb_sel_i,
	input  wire [31:0] wb_dat_i,
	output wire [31:0] wb_dat_o,
	output wire        wb_ack_o,
	// system reset pin
	input  wire        system_reset_low_i,
	// test point pins
	input  wire [7:0]  test_point_port_i,
	output wire [7:0]  test_point_port_o,
	output wire [7:0]  test_point_port_oe_o,
	output wire [7:0]  test_point_pull_down_o,
	// mode option straps
	output wire [3:0]  mode_option_o
);

	// ------------------------------------------------------------------
	// timing constants
	// ------------------------------------------------------------------
	localparam integer HALF_TP0_I  = `TPD_HALF_TP0;
	localparam integer HALF_TP1_I  = `TPD_HALF_TP1;
	localparam integer HALF_TP7_I  = `TPD_HALF_TP7;
	localparam integer HALF_SLOW_I = `TPD_HALF_TP2_SLOW;
	localparam integer HALF_FAST_I = `TPD_HALF_TP2_FAST;

	wire [DIV_W-1:0] half_tp0  = HALF_TP0_I[DIV_W-1:0];
	wire [DIV_W-1:0] half_tp1  = HALF_TP1_I[DIV_W-1:0];
	wire [DIV_W-1:0] half_tp7  = HALF_TP7_I[DIV_W-1:0];
	wire [DIV_W-1:0] half_slow = HALF_SLOW_I[DIV_W-1:0];
	wire [DIV_W-1:0] half_fast = HALF_FAST_I[DIV_W-1:0];

	// ------------------------------------------------------------------
	// pin synchronisers, three stages
	// ------------------------------------------------------------------
	reg [2:0] rstn_sync_q;
	reg [7:0] pin_s1_q;
	reg [7:0] pin_s2_q;
	reg [7:0] pin_s3_q;
	reg       rel_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			rstn_sync_q <= 3'h0;
			pin_s1_q    <= 8'h00;
			pin_s2_q    <= 8'h00;
			pin_s3_q    <= 8'h00;
		end else begin
			rstn_sync_q <= {rstn_sync_q[1:0], system_reset_low_i};
			pin_s1_q    <= test_point_port_i;
			pin_s2_q    <= pin_s1_q;
			pin_s3_q    <= pin_s2_q;
		end
	end

	// ------------------------------------------------------------------
	// pin level filter
	// ------------------------------------------------------------------
	// a bit takes its new level only once stages two and three agree,
	// so a one-cycle glitch on a strap pin never reaches the capture
	reg  [7:0] pin_q;
	wire [7:0] pin_agree = ~(pin_s2_q ^ pin_s3_q);

	always @(posedge clk_i) begin
		if (rst_i) begin
			pin_q <= 8'h00;
		end else begin
			pin_q <= (pin_agree & pin_s3_q) | (~pin_agree & pin_q);
		end
	end

	// reset pin level counts once stages two and three agree
	wire rstn_agree = (rstn_sync_q[1] == rstn_sync_q[2]);
	wire rel_rise   = rstn_agree && rstn_sync_q[2] && !rel_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			rel_q <= 1'b0;
		end else if (rstn_agree) begin
			rel_q <= rstn_sync_q[2];
		end
	end

	// ------------------------------------------------------------------
	// strap capture
	// ------------------------------------------------------------------
	// strap, scenario and mode all load from the filtered level at one edge
	reg [7:0] strap_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			strap_q <= 8'h00;
		end else if (rel_rise) begin
			strap_q <= pin_q;
		end
	end

	// ------------------------------------------------------------------
	// wishbone slave and registers
	// ------------------------------------------------------------------
	reg [2:0]       scen_q;
	reg [3:0]       mode_q;
	reg [DIV_W-1:0] div2_q;
	reg             ack_q;
	reg [31:0]      rdat_q;
	reg [31:0]      rdat_d;

	wire       req     = wb_cyc_i && wb_stb_i && !ack_q;
	wire       wr      = req && wb_we_i;
	wire [1:0] idx     = wb_adr_i[3:2];
	wire [7:0] wb_div  = wb_dat_i[7:0];
	wire       div_lo  = (wb_div[DIV_W-1:0] < half_fast);
	wire       div_hi  = (wb_div[DIV_W-1:0] > half_slow);

	assign wb_ack_o = ack_q;
	assign wb_dat_o = rdat_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			ack_q <= 1'b0;
		end else begin
			ack_q <= req;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			scen_q <= `TPD_SCEN_QUIET;
			mode_q <= 4'h0;
		end else if (rel_rise) begin
			// capture takes priority over a write in the same cycle
			scen_q <= pin_q[2:0];
			mode_q <= pin_q[6:3];
		end else if (wr && idx == `TPD_OFF_CTRL && wb_sel_i[0]) begin
			scen_q <= wb_dat_i[`TPD_CTRL_SCEN_MSB:`TPD_CTRL_SCEN_LSB];
			mode_q <= wb_dat_i[`TPD_CTRL_MODE_MSB:`TPD_CTRL_MODE_LSB];
		end
	end

	// settable clock: half period held inside its documented range
	always @(posedge clk_i) begin
		if (rst_i) begin
			div2_q <= half_slow;
		end else if (wr && idx == `TPD_OFF_DIV && wb_sel_i[0]) begin
			if (div_lo) begin
				div2_q <= half_fast;
			end else if (div_hi) begin
				div2_q <= half_slow;
			end else begin
				div2_q <= wb_div[DIV_W-1:0];
			end
		end
	end

	always @* begin
		rdat_d = 32'h0000_0000;
		case (idx)
			`TPD_OFF_CTRL: begin
				rdat_d[`TPD_CTRL_SCEN_MSB:`TPD_CTRL_SCEN_LSB] = scen_q;
				rdat_d[`TPD_CTRL_MODE_MSB:`TPD_CTRL_MODE_LSB] = mode_q;
			end
			`TPD_OFF_DIV: begin
				rdat_d[DIV_W-1:0] = div2_q;
			end
			`TPD_OFF_STATUS: begin
				rdat_d[`TPD_STAT_STRAP_MSB:`TPD_STAT_STRAP_LSB] = strap_q;
				rdat_d[`TPD_STAT_RUN_BIT] = rel_q;
				rdat_d[`TPD_STAT_PINS_MSB:`TPD_STAT_PINS_LSB] = pin_q;
			end
			default: begin
				rdat_d = 32'h0000_0000;
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			rdat_q <= 32'h0000_0000;
		end else if (req && !wb_we_i) begin
			rdat_q <= rdat_d;
		end else begin
			rdat_q <= 32'h0000_0000;
		end
	end

	// ------------------------------------------------------------------
	// debug clock dividers
	// ------------------------------------------------------------------
	wire clkdbg = rel_q && (scen_q == `TPD_SCEN_CLKDBG);
	wire tp0_clk;
	wire tp1_clk;
	wire tp2_clk;
	wire tp7_clk;

	tpd_clk_div #(.W(DIV_W)) u_div_tp0 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (clkdbg),
		.half_i (half_tp0),
		.clk_o  (tp0_clk)
	);

	tpd_clk_div #(.W(DIV_W)) u_div_tp1 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (clkdbg),
		.half_i (half_tp1),
		.clk_o  (tp1_clk)
	);

	tpd_clk_div #(.W(DIV_W)) u_div_tp2 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (clkdbg),
		.half_i (div2_q),
		.clk_o  (tp2_clk)
	);

	tpd_clk_div #(.W(DIV_W)) u_div_tp7 (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.run_i  (clkdbg),
		.half_i (half_tp7),
		.clk_o  (tp7_clk)
	);

	// ------------------------------------------------------------------
	// pin drivers
	// ------------------------------------------------------------------
	reg [7:0] out_q;
	reg [7:0] oe_q;
	reg [7:0] pull_q;
	reg [3:0] mode_out_q;

	always @(posedge clk_i) begin
		if (rst_i) begin
			out_q <= 8'h00;
			oe_q  <= 8'h00;
		end else if (!rel_q) begin
			out_q <= 8'h00;
			oe_q  <= 8'h00;
		end else if (clkdbg) begin
			out_q <= {tp7_clk, `TPD_CLKDBG_LEVELS, tp2_clk, tp1_clk, tp0_clk};
			oe_q  <= `TPD_CLKDBG_OE;
		end else begin
			// quiet and unlisted scenarios leave every point released
			out_q <= 8'h00;
			oe_q  <= 8'h00;
		end
	end

	always @(posedge clk_i) begin
		if (rst_i) begin
			pull_q     <= `TPD_PULL_ALL;
			mode_out_q <= 4'h0;
		end else begin
			pull_q     <= `TPD_PULL_ALL;
			mode_out_q <= mode_q;
		end
	end

	assign test_point_port_o      = out_q;
	assign test_point_port_oe_o   = oe_q;
	assign test_point_pull_down_o = pull_q;
	assign mode_option_o          = mode_out_q;

endmodule

// [tpd_test_port_checker.sv]
/* assertions on the test-point port bus and pins
   assumes a bind into every tpd_test_port, one clock */
`timescale 1ns/1ps
module tpd_test_port_checker (
	// clock and reset
	input wire       clk_i,
	input wire       rst_i,
	// bus and pins
	input wire       wb_cyc_i,
	input wire       wb_stb_i,
	input wire       wb_ack_o,
	input wire       system_reset_low_i,
	input wire [7:0] test_point_port_i,
	input wire [7:0] test_point_port_o,
	input wire [7:0] test_point_port_oe_o,
	input wire [7:0] test_point_pull_down_o,
	input wire [3:0] mode_option_o
);
	wire       rel = system_reset_low_i;
	wire [7:0] oe  = test_point_port_oe_o;
	wire [7:0] tp  = test_point_port_o;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);
	// ----
	// assertions
	// ----
	a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
		else $error("ack not one pulse");
	a_pins_in_reset: assert property (!rel [*6] |-> oe == 8'h00)
		else $error("pins driven in reset");
	a_pulldown_on: assert property (test_point_pull_down_o == 8'hff)
		else $error("pulldowns off");
	a_oe_all_none: assert property (oe == 8'h00 || oe == 8'hff)
		else $error("partial enable");
	a_static_levels: assert property (oe == 8'hff |-> tp[6:3] == 4'hd)
		else $error("static levels wrong");
	a_fast_clocks: assert property (
		$past(oe, 2) == 8'hff && $past(oe) == 8'hff && oe == 8'hff
		|-> tp[0] != $past(tp[0]) && tp[1] == tp[0])
		else $error("fast clocks wrong");
	a_slow_clock: assert property (
		$rose(tp[7]) && oe == 8'hff
		|-> (tp[7] || oe != 8'hff) [*3] ##1 (!tp[7] || oe != 8'hff))
		else $error("slow clock wrong");
	a_strap_capture: assert property (
		$rose(rel) ##1 rel [*6]
		|-> oe == (($past(test_point_port_i[2:0], 6) == 3'h2) ? 8'hff : 8'h00)
		&& mode_option_o == $past(test_point_port_i[6:3], 6))
		else $error("strap not applied");
	a_strap_held: assert property ((rel && !wb_cyc_i) [*7] |=> $stable(oe) && $stable(mode_option_o))
		else $error("outputs moved without cause");
	c_clk_debug: cover property (oe == 8'hff);
	c_release: cover property ($rose(rel));
	c_slow: cover property ($rose(tp[7]) && oe == 8'hff);
endmodule

bind tpd_test_port tpd_test_port_checker i_chk (.clk_i(clk_i), .rst_i(rst_i),
	.wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
	.system_reset_low_i(system_reset_low_i), .test_point_port_i(test_point_port_i),
	.test_point_port_o(test_point_port_o), .test_point_port_oe_o(test_point_port_oe_o),
	.test_point_pull_down_o(test_point_pull_down_o), .mode_option_o(mode_option_o));

// [tpd_strap_board.sv]
/* board model: strap pullups and probes on the test points
   assumes the device drives a pin only while its enable is high */
`timescale 1ns/1ps
module tpd_strap_board (
	// fitted pullups
	input  wire [7:0] pull_up_i,
	// device side
	input  wire [7:0] drive_i,
	input  wire [7:0] drive_oe_i,
	input  wire [7:0] pull_down_i,
	// resolved levels
	output wire [7:0] pin_o
);
	// undriven pins settle to the pull; a floating pin shows the inverse of the present drive_i
	assign pin_o = (drive_oe_i & drive_i)
		| (~drive_oe_i & (pull_up_i | (~pull_down_i & ~drive_i)));
endmodule

// [tpd_test_port_test.sv]
/* self-checking bench for the test-point port
   assumes a 50 MHz clock and the board model on the pins */
`timescale 1ns/1ps
module tpd_test_port_test;
	logic        clk_i = 1'b0;
	logic        rst_i = 1'b1;
	logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, sys_low = 1'b0;
	logic [3:0]  adr = 4'h0, sel = 4'h0;
	logic [31:0] dat = 32'h0, r;
	logic [7:0]  strap = 8'h00;
	wire  [31:0] rdat;
	wire         ack;
	wire  [7:0]  pin, tp, oe, pd;
	wire  [3:0]  mode;
	int          n_errors = 0, checks_done = 0, cycles = 0, cnt;

	initial forever #10 clk_i = ~clk_i;

	tpd_test_port i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat),
		.wb_ack_o(ack), .system_reset_low_i(sys_low), .test_point_port_i(pin),
		.test_point_port_o(tp), .test_point_port_oe_o(oe), .test_point_pull_down_o(pd),
		.mode_option_o(mode));
	tpd_strap_board i_board (.pull_up_i(strap), .drive_i(tp), .drive_oe_i(oe),
		.pull_down_i(pd), .pin_o(pin));

	task automatic chk(input string what, input logic [31:0] seen, exp);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wb(input logic w, input logic [3:0] s, a, input logic [31:0] d);
		@(posedge clk_i);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= s;
		adr <= a;
		dat <= d;
		// wait for ack; only the bench watchdog ends a hung wait
		do @(posedge clk_i);
		while (ack !== 1'b1);
		r = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask

	// hold the reset pin low with new straps, then release it
	task automatic boot(input logic [7:0] s);
		@(posedge clk_i);
		sys_low <= 1'b0;
		strap <= s;
		repeat (8) @(posedge clk_i);
		sys_low <= 1'b1;
		repeat (10) @(posedge clk_i);
	endtask

	task automatic tog(input int b, n);
		logic p;
		cnt = 0;
		p = tp[b];
		repeat (n) begin
			@(posedge clk_i);
			if (tp[b] !== p) cnt++;
			p = tp[b];
		end
	endtask

	task automatic test_done;
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	always @(posedge clk_i) begin
		cycles <= cycles + 1;
		if (cycles == 3000) begin
			n_errors++;
			test_done;
		end
	end

	initial begin
		repeat (8) @(posedge clk_i);
		rst_i <= 1'b0;
		wb(0, 4'hf, 4'h0, 0);
		chk("ctrl reset", r, 32'h0);
		wb(0, 4'hf, 4'h4, 0);
		chk("div reset", r, 32'h23);
		wb(1, 4'hf, 4'h4, 32'h0);
		wb(0, 4'hf, 4'h4, 0);
		chk("div clamp low", r, 32'h1);
		wb(1, 4'hf, 4'h4, 32'hff);
		wb(0, 4'hf, 4'h4, 0);
		chk("div clamp high", r, 32'h23);
		wb(1, 4'hf, 4'h8, 32'hff);
		wb(0, 4'hf, 4'h8, 0);
		chk("status read only", r, 32'h0);
		wb(0, 4'hf, 4'hc, 0);
		chk("unmapped", r, 32'h0);
		boot(8'h00);
		chk("quiet enable", oe, 8'h00);
		chk("pulldowns", pd, 8'hff);
		wb(0, 4'hf, 4'h8, 0);
		chk("status quiet", r, 32'h100);
		boot(8'h02);
		chk("debug enable", oe, 8'hff);
		chk("static levels", tp[6:3], 4'hd);
		tog(0, 8);
		chk("tp0 toggles", cnt, 8);
		tog(7, 24);
		chk("tp7 toggles", cnt, 8);
		tog(2, 70);
		chk("tp2 slow toggles", cnt, 2);
		wb(1, 4'hf, 4'h4, 32'h2);
		// the running 35-cycle half period must run out first
		repeat (40) @(posedge clk_i);
		tog(2, 20);
		chk("tp2 fast toggles", cnt, 10);
		strap <= 8'h00;
		repeat (10) @(posedge clk_i);
		chk("strap held", oe, 8'hff);
		wb(0, 4'hf, 4'h8, 0);
		chk("strap kept", r[8:0], 9'h102);
		wb(1, 4'hf, 4'h0, 32'h0);
		repeat (3) @(posedge clk_i);
		chk("software quiet", oe, 8'h00);
		wb(1, 4'he, 4'h0, 32'h7a);
		repeat (3) @(posedge clk_i);
		chk("byte lane off", mode, 4'h0);
		wb(1, 4'hf, 4'h0, 32'h7a);
		repeat (3) @(posedge clk_i);
		chk("software mode", mode, 4'hf);
		chk("software debug", oe, 8'hff);
		boot(8'h78);
		chk("strap mode", mode, 4'hf);
		chk("mode quiet", oe, 8'h00);
		test_done;
	end
endmodule
